/* core/tc_timer.sv */
// 16-bit timer/counter with prescaler, source select and Avalon-MM registers
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "tc_defines.svh"

module tc_timer
	import tc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Count sources
	input wire logic ext_count_input,
	input wire logic low_freq_osc,
	// Gate subsystem and power state
	input wire logic gate_count_enable,
	input wire logic sleep_mode,
	// Overflow interrupt and wake request
	output logic irq
);

	tc_state_t s_r;
	tc_state_t s_nxt;

	logic bus_req;
	logic bus_commit;
	logic wr_low;
	logic wr_high;
	logic ext_level;
	logic ext_rise;
	logic ext_fall;
	logic lf_rise;
	logic src_tick;
	logic count_on;
	logic [2:0] pre_mask;
	logic pre_done;
	logic inc;
	logic ovf;

	// Decode, strobes and count path
	logic awake;
	logic sel_low;
	logic sel_high;
	logic sel_control;
	logic sel_gate;
	logic sel_clear;
	logic sel_enable;
	logic wr_control;
	logic wr_gate;
	logic wr_clear;
	logic wr_enable;
	logic count_write;
	logic disarm;
	logic rd_take;
	logic tick_instr;
	logic tick_system;
	logic tick_ext;
	logic tick_lf;
	logic pre_step;
	logic [2:0] pre_next;
	logic count_max;
	logic [15:0] count_plus;
	logic [7:0] wr_byte;
	logic ctrl_run;
	logic ctrl_async;
	logic [1:0] ctrl_prescale;
	logic [1:0] ctrl_clock;
	logic ctrl_gate;

	// Reset images of the control registers, so each field is sliced on purpose
	localparam logic [7:0] CTRL_RST = `TC_TIMER_CONTROL_RST;
	localparam logic [7:0] GATE_RST = `TC_GATE_CONTROL_RST;

	// Read-back value of an address, unmapped and write-only read zero
	function automatic logic [31:0] read_mux(input tc_state_t s, input logic [4:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			`TC_OFS_COUNT_LOW: d[7:0] = s.count[7:0];
			`TC_OFS_COUNT_HIGH: d[7:0] = s.count[15:8];
			`TC_OFS_TIMER_CONTROL:
			begin
				d[`TC_RUN_ENABLE_BIT] = s.run_enable;
				d[`TC_ASYNC_SELECT_BIT] = s.async_select;
				d[`TC_PRESCALE_LSB +: 2] = s.prescale_select;
				d[`TC_CLOCK_SELECT_LSB +: 2] = s.clock_select;
			end
			`TC_OFS_GATE_CONTROL: d[`TC_GATE_ENABLE_BIT] = s.gate_enable;
			`TC_OFS_IRQ_STATUS: d[`TC_OVERFLOW_BIT] = s.overflow_flag;
			`TC_OFS_IRQ_ENABLE: d[`TC_OVERFLOW_BIT] = s.overflow_irq_en;
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction : read_mux

	// One wait cycle per access, then the request is taken
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~s_r.bus_ack;
	assign bus_commit = avs_write & s_r.bus_ack & avs_byteenable[0];
	assign wr_byte = avs_writedata[7:0];
	assign rd_take = avs_read & ~s_r.bus_ack;
	assign avs_readdata = s_r.readdata;
	assign irq = s_r.overflow_flag & s_r.overflow_irq_en;

	// Address decode, one select per register that software writes
	assign sel_low = (avs_address == `TC_OFS_COUNT_LOW);
	assign sel_high = (avs_address == `TC_OFS_COUNT_HIGH);
	assign sel_control = (avs_address == `TC_OFS_TIMER_CONTROL);
	assign sel_gate = (avs_address == `TC_OFS_GATE_CONTROL);
	assign sel_clear = (avs_address == `TC_OFS_IRQ_CLEAR);
	assign sel_enable = (avs_address == `TC_OFS_IRQ_ENABLE);
	assign wr_low = bus_commit & sel_low;
	assign wr_high = bus_commit & sel_high;
	assign wr_control = bus_commit & sel_control;
	assign wr_gate = bus_commit & sel_gate;
	assign wr_enable = bus_commit & sel_enable;
	// Only a one in the overflow position clears; other bits are ignored
	assign wr_clear = bus_commit & sel_clear & wr_byte[`TC_OVERFLOW_BIT];

	// Write data fields of the control registers
	assign ctrl_run = wr_byte[`TC_RUN_ENABLE_BIT];
	assign ctrl_async = wr_byte[`TC_ASYNC_SELECT_BIT];
	assign ctrl_prescale = wr_byte[`TC_PRESCALE_LSB +: 2];
	assign ctrl_clock = wr_byte[`TC_CLOCK_SELECT_LSB +: 2];
	assign ctrl_gate = wr_byte[`TC_GATE_ENABLE_BIT];

	// Counter write beats a same-cycle increment in the written byte and restarts the prescaler
	assign count_write = wr_low | wr_high;
	// A stopped timer or a counter write waits for a fresh falling edge
	assign disarm = ~s_r.run_enable | count_write;
	assign awake = ~sleep_mode;
	assign count_plus = s_r.count + 16'h0001;
	assign count_max = (s_r.count == 16'hFFFF);

	always_comb
	begin
		// Async mode reads the plain synchroniser, sync mode one aligned stage later
		ext_level = s_r.async_select ? s_r.ext_sync : s_r.ext_align;
		ext_rise = ext_level & ~s_r.ext_prev;
		ext_fall = ~ext_level & s_r.ext_prev;
		lf_rise = s_r.lf_sync & ~s_r.lf_prev;

		// System clock is stopped in sleep; only the async pin path survives
		tick_instr = awake & (s_r.instr_div == `TC_INSTR_LAST);
		tick_system = awake;
		tick_ext = ext_rise & s_r.armed & (s_r.async_select | awake);
		tick_lf = awake & lf_rise;

		src_tick = 1'b0;
		case (s_r.clock_select)
			`TC_CS_INSTR: src_tick = tick_instr;
			`TC_CS_SYSTEM: src_tick = tick_system;
			`TC_CS_EXTERNAL: src_tick = tick_ext;
			`TC_CS_LOW_FREQ: src_tick = tick_lf;
			default: src_tick = 1'b0;
		endcase

		count_on = s_r.run_enable & (~s_r.gate_enable | gate_count_enable);
		pre_mask = 3'((4'h1 << s_r.prescale_select) - 4'h1);
		pre_done = (s_r.prescale_cnt & pre_mask) == pre_mask;
		pre_step = count_on & src_tick;
		pre_next = pre_done ? 3'h0 : s_r.prescale_cnt + 3'h1;
		inc = pre_step & pre_done;
		ovf = inc & count_max;

		s_nxt = s_r;

		// Pin synchronisers
		s_nxt.ext_meta = ext_count_input;
		s_nxt.ext_sync = s_r.ext_meta;
		s_nxt.ext_align = s_r.ext_sync;
		s_nxt.ext_prev = ext_level;
		s_nxt.lf_meta = low_freq_osc;
		s_nxt.lf_sync = s_r.lf_meta;
		s_nxt.lf_prev = s_r.lf_sync;

		// Instruction-cycle divider, free running while awake
		if (!sleep_mode)
		begin
			s_nxt.instr_div = s_r.instr_div + 2'h1;
		end

		// Falling edge arms the pin counter; disable or counter write disarms
		if (ext_fall)
		begin
			s_nxt.armed = 1'b1;
		end
		if (disarm)
		begin
			s_nxt.armed = 1'b0;
		end

		// Prescaler and counter
		if (pre_step)
		begin
			s_nxt.prescale_cnt = pre_next;
		end
		if (inc)
		begin
			s_nxt.count = count_plus;
		end
		if (count_write)
		begin
			s_nxt.prescale_cnt = 3'h0;
		end
		if (wr_low)
		begin
			s_nxt.count[7:0] = wr_byte;
		end
		if (wr_high)
		begin
			s_nxt.count[15:8] = wr_byte;
		end

		// Control registers
		if (wr_control)
		begin
			s_nxt.run_enable = ctrl_run;
			s_nxt.async_select = ctrl_async;
			s_nxt.prescale_select = ctrl_prescale;
			s_nxt.clock_select = ctrl_clock;
		end
		if (wr_gate)
		begin
			s_nxt.gate_enable = ctrl_gate;
		end
		if (wr_enable)
		begin
			s_nxt.overflow_irq_en = wr_byte[`TC_OVERFLOW_BIT];
		end

		// Overflow flag: a rollover in the clearing cycle still sets it
		if (wr_clear)
		begin
			s_nxt.overflow_flag = 1'b0;
		end
		if (ovf)
		begin
			s_nxt.overflow_flag = 1'b1;
		end

		// Bus answer, read data captured in the wait cycle
		s_nxt.bus_ack = bus_req & ~s_r.bus_ack;
		if (rd_take)
		begin
			s_nxt.readdata = read_mux(s_r, avs_address);
		end

		// Synchronous reset; pin stages clear to the idle low level of both inputs
		if (!nrst)
		begin
			s_nxt.ext_meta = 1'b0;
			s_nxt.ext_sync = 1'b0;
			s_nxt.ext_align = 1'b0;
			s_nxt.ext_prev = 1'b0;
			s_nxt.lf_meta = 1'b0;
			s_nxt.lf_sync = 1'b0;
			s_nxt.lf_prev = 1'b0;
			s_nxt.armed = 1'b0;
			s_nxt.instr_div = 2'h0;
			s_nxt.prescale_cnt = 3'h0;
			s_nxt.count = `TC_COUNT_RST;
			s_nxt.run_enable = CTRL_RST[`TC_RUN_ENABLE_BIT];
			s_nxt.gate_enable = GATE_RST[`TC_GATE_ENABLE_BIT];
			s_nxt.async_select = CTRL_RST[`TC_ASYNC_SELECT_BIT];
			s_nxt.prescale_select = CTRL_RST[`TC_PRESCALE_LSB +: 2];
			s_nxt.clock_select = CTRL_RST[`TC_CLOCK_SELECT_LSB +: 2];
			s_nxt.overflow_flag = 1'b0;
			s_nxt.overflow_irq_en = 1'b0;
			s_nxt.bus_ack = 1'b0;
			s_nxt.readdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge clock)
	begin
		s_r <= s_nxt;
	end

endmodule : tc_timer

/* core/tc_defines.svh */
// Offsets, field positions, reset values and timing counts of the 16-bit timer/counter
`ifndef TC_DEFINES_SVH
`define TC_DEFINES_SVH

// Byte addresses on the register bus
`define TC_OFS_COUNT_LOW 5'h00
`define TC_OFS_COUNT_HIGH 5'h04
`define TC_OFS_TIMER_CONTROL 5'h08
`define TC_OFS_GATE_CONTROL 5'h0C
`define TC_OFS_IRQ_STATUS 5'h10
`define TC_OFS_IRQ_CLEAR 5'h14
`define TC_OFS_IRQ_ENABLE 5'h18

// timer_control fields
`define TC_RUN_ENABLE_BIT 0
`define TC_ASYNC_SELECT_BIT 2
`define TC_PRESCALE_LSB 4
`define TC_CLOCK_SELECT_LSB 6

// gate_control fields
`define TC_GATE_ENABLE_BIT 7

// Interrupt bit position
`define TC_OVERFLOW_BIT 0

// Reset values
`define TC_COUNT_RST 16'h0000
`define TC_TIMER_CONTROL_RST 8'h00
`define TC_GATE_CONTROL_RST 8'h00

// Clock-select codes
`define TC_CS_INSTR 2'h0
`define TC_CS_SYSTEM 2'h1
`define TC_CS_EXTERNAL 2'h2
`define TC_CS_LOW_FREQ 2'h3

// System clocks per instruction cycle, last phase of the divider
`define TC_INSTR_PHASES 4
`define TC_INSTR_LAST 2'h3

`endif

/* core/tc_pkg.sv */
// Types of the 16-bit timer/counter
package tc_pkg;

	// Whole state of the timer, registered once per clock
	typedef struct packed {
		logic ext_meta;
		logic ext_sync;
		logic ext_align;
		logic ext_prev;
		logic lf_meta;
		logic lf_sync;
		logic lf_prev;
		logic armed;
		logic [1:0] instr_div;
		logic [2:0] prescale_cnt;
		logic [15:0] count;
		logic run_enable;
		logic gate_enable;
		logic async_select;
		logic [1:0] prescale_select;
		logic [1:0] clock_select;
		logic overflow_flag;
		logic overflow_irq_en;
		logic bus_ack;
		logic [31:0] readdata;
	} tc_state_t;

endpackage : tc_pkg

/* verification/tc_timer_checker.sv */
// Bus and interrupt assertions for the timer
`timescale 1ns/1ps
module tc_timer_checker (
	// Watched ports
	input wire logic clock,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	wire logic req = avs_read | avs_write;
	wire logic rd = avs_read & ~avs_waitrequest;
	wire logic wd = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire logic wclr = wd && avs_address == 5'h14;
	wire logic wen = wd && avs_address == 5'h18;
	a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest) else $error("no wait");
	a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("long");
	a_idle_free: assert property (!req |-> !avs_waitrequest) else $error("idle wait");
	a_unmapped_zero: assert property (rd && avs_address == 5'h1C |-> avs_readdata == 32'h0)
		else $error("unmapped");
	a_upper_zero: assert property (rd |-> avs_readdata[31:8] == 24'h0) else $error("upper");
	a_data_hold: assert property (!avs_read |=> $stable(avs_readdata)) else $error("data");
	a_irq_reset: assert property (disable iff (1'b0) !nrst |=> !irq) else $error("rst irq");
	a_irq_clear: assert property (wclr && avs_writedata[0] |=> !irq) else $error("clr");
	a_irq_mask: assert property (wen && !avs_writedata[0] |=> !irq) else $error("mask");
	a_irq_sticky: assert property (irq && !wclr && !wen |=> irq) else $error("sticky");
endmodule : tc_timer_checker
bind tc_timer tc_timer_checker tc_timer_checker_inst (.clock, .nrst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);

/* verification/tc_ext_source.sv */
// External count signal source for the timer
`timescale 1ns/1ps
module tc_ext_source (
	// System clock
	input wire logic clock,
	// Count pin
	output logic ext_count_input
);
	initial ext_count_input = 1'b0;
	// Each pulse falls then rises, levels held three clocks
	task automatic pulses(input int n);
		repeat (n)
		begin
			repeat (3) @(posedge clock);
			ext_count_input <= 1'b0;
			repeat (3) @(posedge clock);
			ext_count_input <= 1'b1;
		end
	endtask : pulses
	task automatic level(input logic v);
		@(posedge clock);
		ext_count_input <= v;
	endtask : level
endmodule : tc_ext_source

/* verification/tc_timer_bench.sv */
// Self-checking bench of the timer
`timescale 1ns/1ps
module tc_timer_bench;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_count_input;
	logic low_freq_osc = 1'b0;
	logic gate_count_enable = 1'b1;
	logic sleep_mode = 1'b0;
	logic irq;
	logic [31:0] rv;
	logic [15:0] cv;
	logic iv;
	int mismatches = 0;
	int tests_run = 0;
	int lf_div = 0;
	always #5 clock = ~clock;
	// Slow oscillator, period forty clocks, toggled on the rising edge
	always @(posedge clock)
	begin
		lf_div <= (lf_div == 19) ? 0 : lf_div + 1;
		if (lf_div == 19)
			low_freq_osc <= ~low_freq_osc;
	end
	tc_timer tc_timer_inst (.clock, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_count_input, .low_freq_osc,
		.gate_count_enable, .sleep_mode, .irq);
	tc_ext_source tc_ext_source_inst (.clock, .ext_count_input);
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		// Hold the request until waitrequest is seen low at a rising edge
		do
		begin
			@(posedge clock);
		end
		while (avs_waitrequest !== 1'b0);
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// One idle edge so the next request never reuses this time step
		@(posedge clock);
		iv = irq;
	endtask : bus
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int t);
		tests_run++;
		if (^g === 1'bx || g + t < e || g > e + t)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic rdc();
		bus(0, 5'h00, 8'h00);
		cv[7:0] = rv[7:0];
		bus(0, 5'h04, 8'h00);
		cv[15:8] = rv[7:0];
	endtask : rdc
	// Counts for w+3 clocks from a cleared counter, then reads it stopped
	task automatic run(input logic [7:0] c, input int w);
		bus(1, 5'h00, 8'h00);
		bus(1, 5'h04, 8'h00);
		bus(1, 5'h08, c | 8'h01);
		repeat (w) @(posedge clock);
		bus(1, 5'h08, c);
		rdc();
	endtask : run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		// About six times the length of a clean run
		#200000;
		mismatches++;
		tally_and_finish();
	end
	initial
	begin
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		bus(0, 5'h08, 8'h00);
		chk("control", 0, rv, 0);
		bus(0, 5'h1C, 8'h00);
		chk("unmapped", 0, rv, 0);
		bus(1, 5'h00, 8'h34);
		bus(1, 5'h04, 8'h12);
		avs_byteenable <= 4'h0;
		bus(1, 5'h00, 8'hAA);
		avs_byteenable <= 4'hF;
		rdc();
		chk("bytes", 16'h1234, cv, 0);
		$display("test registers done");
		for (int k = 0; k < 8; k++)
		begin
			run({k < 4 ? 2'h1 : 2'h0, k[1:0], 4'h0}, 255);
			chk("rate", 258 / ((k < 4 ? 1 : 4) << k[1:0]), cv, 2);
		end
		run(8'hC0, 395);
		chk("low freq", 10, cv, 1);
		$display("test rates done");
		bus(1, 5'h0C, 8'h80);
		gate_count_enable <= 1'b0;
		run(8'h40, 255);
		chk("gate shut", 0, cv, 0);
		gate_count_enable <= 1'b1;
		run(8'h40, 255);
		chk("gate open", 258, cv, 2);
		bus(1, 5'h0C, 8'h00);
		$display("test gate done");
		for (int a = 0; a < 3; a++)
		begin
			sleep_mode <= (a > 0);
			run(a == 2 ? 8'h84 : 8'h80, 0);
			bus(1, 5'h08, a == 2 ? 8'h85 : 8'h81);
			tc_ext_source_inst.level(1'b1);
			tc_ext_source_inst.pulses(4);
			repeat (8) @(posedge clock);
			bus(1, 5'h08, 8'h80);
			tc_ext_source_inst.level(1'b0);
			rdc();
			chk("external", a == 1 ? 0 : 4, cv, 0);
		end
		sleep_mode <= 1'b0;
		run(8'h80, 0);
		bus(1, 5'h08, 8'h81);
		tc_ext_source_inst.level(1'b1);
		tc_ext_source_inst.pulses(2);
		bus(1, 5'h08, 8'h85);
		tc_ext_source_inst.pulses(2);
		repeat (8) @(posedge clock);
		bus(1, 5'h08, 8'h80);
		tc_ext_source_inst.level(1'b0);
		rdc();
		chk("sync switch", 4, cv, 1);
		$display("test external done");
		bus(1, 5'h00, 8'hFE);
		bus(1, 5'h04, 8'hFF);
		bus(1, 5'h18, 8'h01);
		bus(1, 5'h08, 8'h41);
		bus(1, 5'h08, 8'h40);
		rdc();
		chk("wrap", 1, cv, 1);
		chk("irq", 1, iv, 0);
		bus(1, 5'h18, 8'h00);
		chk("masked", 0, iv, 0);
		bus(0, 5'h10, 8'h00);
		chk("sticky", 1, rv, 0);
		bus(1, 5'h18, 8'h01);
		bus(1, 5'h14, 8'h01);
		chk("irq low", 0, iv, 0);
		bus(0, 5'h10, 8'h00);
		chk("cleared", 0, rv, 0);
		$display("test overflow done");
		tally_and_finish();
	end
endmodule : tc_timer_bench
